//--- rtl/tid_pkg.sv
package tid_pkg;

    // Widths of the scan registers, the bit counter and the scan clock synchronizer
    localparam int IR_W = 10;
    localparam int DR_W = 32;
    localparam int BIT_CNT_W = 5;
    localparam int SYNC_W = 3;

    // Instruction codes
    localparam logic [IR_W-1:0] OP_EXTEST = 10'h3C0;
    localparam logic [IR_W-1:0] OP_SAMPLE = 10'h3C1;
    localparam logic [IR_W-1:0] OP_USER_CHAIN_A = 10'h3C2;
    localparam logic [IR_W-1:0] OP_USER_CHAIN_B = 10'h3C3;
    localparam logic [IR_W-1:0] OP_USER_CHAIN_C = 10'h3E2;
    localparam logic [IR_W-1:0] OP_USER_CHAIN_D = 10'h3E3;
    localparam logic [IR_W-1:0] OP_CFG_READ = 10'h3C4;
    localparam logic [IR_W-1:0] OP_CFG_LOAD = 10'h3C5;
    localparam logic [IR_W-1:0] OP_INTEST = 10'h3C7;
    localparam logic [IR_W-1:0] OP_DESIGN_ID = 10'h3C8;
    localparam logic [IR_W-1:0] OP_DEVICE_ID = 10'h3C9;
    localparam logic [IR_W-1:0] OP_HIGHZ = 10'h3CA;
    localparam logic [IR_W-1:0] OP_RECONFIG_REQ = 10'h3CB;
    localparam logic [IR_W-1:0] OP_STARTUP_CLK = 10'h3CC;
    localparam logic [IR_W-1:0] OP_SHUTDOWN_CLK = 10'h3CD;
    localparam logic [IR_W-1:0] OP_MONITOR_PORT = 10'h3F7;
    localparam logic [IR_W-1:0] OP_INSYS_ENABLE = 10'h3D0;
    localparam logic [IR_W-1:0] OP_INSYS_PROGRAM = 10'h3D1;
    localparam logic [IR_W-1:0] OP_SECURITY_TOGGLE = 10'h3D2;
    localparam logic [IR_W-1:0] OP_INSYS_NOOP = 10'h3D4;
    localparam logic [IR_W-1:0] OP_INSYS_READ = 10'h3D5;
    localparam logic [IR_W-1:0] OP_INSYS_DISABLE = 10'h3D7;
    localparam logic [IR_W-1:0] OP_BYPASS = 10'h3FF;

    // Instruction capture pattern fields
    localparam logic [1:0] IR_CAP_FIXED = 2'h1;
    localparam logic [3:0] IR_CAP_RSVD = 4'h0;

    // Design code read when blank or unprogrammed
    localparam logic [DR_W-1:0] DESIGN_ID_BLANK = 32'hFFFFFFFF;
    // Arbitrary neutral device code; lowest bit must stay 1
    localparam logic [DR_W-1:0] DEVICE_ID_DEFAULT = 32'h0ABC_D001;

    // Test access port controller states
    typedef enum logic [3:0] {
        TAP_RESET = 4'h0,
        TAP_IDLE = 4'h1,
        TAP_SEL_DR = 4'h2,
        TAP_CAP_DR = 4'h3,
        TAP_SH_DR = 4'h4,
        TAP_EX1_DR = 4'h5,
        TAP_PAU_DR = 4'h6,
        TAP_EX2_DR = 4'h7,
        TAP_UPD_DR = 4'h8,
        TAP_SEL_IR = 4'h9,
        TAP_CAP_IR = 4'hA,
        TAP_SH_IR = 4'hB,
        TAP_EX1_IR = 4'hC,
        TAP_PAU_IR = 4'hD,
        TAP_EX2_IR = 4'hE,
        TAP_UPD_IR = 4'hF
    } tid_tap_e;

    // Shared signals toward user scan chains
    typedef struct packed {
        logic [3:0] sel;
        logic tdi;
        logic reset;
        logic capture;
        logic shift;
        logic update;
        logic step;
    } tid_user_port_s;

    // Configuration engine status inputs
    typedef struct packed {
        logic done;
        logic init_complete;
        logic insys_config_active_flag;
        logic insys_config_finished_flag;
    } tid_cfg_status_s;

endpackage : tid_pkg

//--- rtl/tid_decode.sv
`timescale 1ns/1ps

// Configuration word FIFO between scan side and configuration engine
module tid_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } tid_fifo_state_s;

    tid_fifo_state_s st_r;
    tid_fifo_state_s st_nxt;
    logic push;
    logic pop;

    // Honest flags straight from the occupancy count
    assign o_in_ready = (st_r.count != (AW + 1)'(DEPTH));
    assign o_out_valid = (st_r.count != '0);
    assign o_out_data = st_r.mem[st_r.rd_ptr];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // Pointer wrap also works for depths that are not a power of two
    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wr_ptr] = i_in_data;
            st_nxt.wr_ptr = (st_r.wr_ptr == AW'(DEPTH - 1)) ? '0 : st_r.wr_ptr + 1'b1;
        end
        if (pop) begin
            st_nxt.rd_ptr = (st_r.rd_ptr == AW'(DEPTH - 1)) ? '0 : st_r.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            st_nxt.count = st_r.count + 1'b1;
        end else if (pop && !push) begin
            st_nxt.count = st_r.count - 1'b1;
        end
    end

    // State register
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule : tid_fifo

// Instruction decode and data registers behind the test access port
module tid_decode #(
    parameter logic [31:0] DEVICE_ID = tid_pkg::DEVICE_ID_DEFAULT,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    output logic o_tdo,
    output logic o_tdo_oe,
    input wire tid_pkg::tid_cfg_status_s i_status,
    input wire logic i_configured,
    input wire logic [31:0] i_design_id,
    input wire logic i_startup_clock_source,
    input wire logic [31:0] i_readback_word,
    input wire logic i_bscan_tdo,
    input wire logic [3:0] i_user_tdo,
    input wire logic i_mon_tdo,
    output logic o_bscan_extest,
    output logic o_bscan_sample,
    output logic o_bscan_intest,
    output logic o_highz,
    output logic o_mon_sel,
    output logic o_key_read,
    output logic o_insys_program_en,
    output logic o_secure,
    output tid_pkg::tid_user_port_s o_user,
    output logic o_reconfig_req,
    output logic o_startup_step,
    output logic o_shutdown_step,
    output logic o_insys_shutdown,
    output logic o_insys_startup,
    output logic o_readback_req,
    output logic o_cfg_overrun,
    output logic o_cfg_valid,
    input wire logic i_cfg_ready,
    output logic [31:0] o_cfg_word
);
    typedef struct packed {
        logic [tid_pkg::SYNC_W-1:0] tck_sync;
        logic [1:0] tms_sync;
        logic [1:0] tdi_sync;
        tid_pkg::tid_tap_e tap;
        logic [tid_pkg::IR_W-1:0] ir_shift;
        logic [tid_pkg::IR_W-1:0] ir;
        logic [tid_pkg::DR_W-1:0] dr;
        logic bypass_flop;
        logic [tid_pkg::BIT_CNT_W-1:0] bit_cnt;
        logic tdo;
        logic tdo_oe;
        logic secure;
        logic overrun;
        logic push;
        logic [tid_pkg::DR_W-1:0] push_word;
        logic reconfig_req;
        logic startup_step;
        logic shutdown_step;
        logic insys_shutdown;
        logic insys_startup;
        logic readback_req;
    } tid_state_s;

    tid_state_s st_r;
    tid_state_s st_nxt;
    logic tck_rise;
    logic tck_fall;
    logic tms;
    logic tdi;
    logic fifo_ready;
    logic [3:0] user_hit;
    logic cfg_load;
    logic cfg_read;
    logic cfg_path;
    logic dr_tdo;
    tid_pkg::tid_tap_e tap_next;

    // Edges found on the second and third stage; first stage feeds only the second
    assign tck_rise = st_r.tck_sync[1] && !st_r.tck_sync[2];
    assign tck_fall = !st_r.tck_sync[1] && st_r.tck_sync[2];
    assign tms = st_r.tms_sync[1];
    assign tdi = st_r.tdi_sync[1];

    // Decode of the latched instruction
    assign o_bscan_extest = (st_r.ir == tid_pkg::OP_EXTEST);
    assign o_bscan_sample = (st_r.ir == tid_pkg::OP_SAMPLE);
    assign o_bscan_intest = (st_r.ir == tid_pkg::OP_INTEST);
    assign user_hit[0] = (st_r.ir == tid_pkg::OP_USER_CHAIN_A);
    assign user_hit[1] = (st_r.ir == tid_pkg::OP_USER_CHAIN_B);
    assign user_hit[2] = (st_r.ir == tid_pkg::OP_USER_CHAIN_C);
    assign user_hit[3] = (st_r.ir == tid_pkg::OP_USER_CHAIN_D);
    assign cfg_read = (st_r.ir == tid_pkg::OP_CFG_READ)
        || (st_r.ir == tid_pkg::OP_INSYS_READ);
    assign cfg_load = (st_r.ir == tid_pkg::OP_CFG_LOAD)
        || (st_r.ir == tid_pkg::OP_INSYS_PROGRAM);
    assign cfg_path = cfg_read || cfg_load;
    assign o_highz = (st_r.ir == tid_pkg::OP_HIGHZ);
    assign o_mon_sel = (st_r.ir == tid_pkg::OP_MONITOR_PORT);
    assign o_key_read = (st_r.ir == tid_pkg::OP_INSYS_READ);
    assign o_insys_program_en = (st_r.ir == tid_pkg::OP_INSYS_PROGRAM);

    // User chains stay deselected before configuration
    assign o_user.sel = i_configured ? user_hit : 4'h0;
    assign o_user.tdi = tdi;
    assign o_user.reset = (st_r.tap == tid_pkg::TAP_RESET);
    assign o_user.capture = (st_r.tap == tid_pkg::TAP_CAP_DR);
    assign o_user.shift = (st_r.tap == tid_pkg::TAP_SH_DR);
    assign o_user.update = (st_r.tap == tid_pkg::TAP_UPD_DR);
    assign o_user.step = tck_rise;

    // Registered outputs
    assign o_tdo = st_r.tdo;
    assign o_tdo_oe = st_r.tdo_oe;
    assign o_secure = st_r.secure;
    assign o_cfg_overrun = st_r.overrun;
    assign o_reconfig_req = st_r.reconfig_req;
    assign o_startup_step = st_r.startup_step;
    assign o_shutdown_step = st_r.shutdown_step;
    assign o_insys_shutdown = st_r.insys_shutdown;
    assign o_insys_startup = st_r.insys_startup;
    assign o_readback_req = st_r.readback_req;

    // Serial output of the selected data register
    always_comb begin
        if (o_bscan_extest || o_bscan_sample || o_bscan_intest) begin
            dr_tdo = i_bscan_tdo;
        end else if (o_user.sel != 4'h0) begin
            dr_tdo = |(i_user_tdo & o_user.sel);
        end else if (o_mon_sel) begin
            dr_tdo = i_mon_tdo;
        end else if (cfg_path) begin
            dr_tdo = st_r.dr[tid_pkg::DR_W-1];
        end else if ((st_r.ir == tid_pkg::OP_DESIGN_ID)
            || (st_r.ir == tid_pkg::OP_DEVICE_ID)) begin
            dr_tdo = st_r.dr[0];
        end else begin
            // Bypass, high-Z, no-op, action codes and undefined codes
            dr_tdo = st_r.bypass_flop;
        end
    end

    // Controller transitions, sampled on the scan clock rising edge
    always_comb begin
        case (st_r.tap)
            tid_pkg::TAP_RESET: tap_next = tms ? tid_pkg::TAP_RESET : tid_pkg::TAP_IDLE;
            tid_pkg::TAP_IDLE: tap_next = tms ? tid_pkg::TAP_SEL_DR : tid_pkg::TAP_IDLE;
            tid_pkg::TAP_SEL_DR: tap_next = tms ? tid_pkg::TAP_SEL_IR : tid_pkg::TAP_CAP_DR;
            tid_pkg::TAP_CAP_DR: tap_next = tms ? tid_pkg::TAP_EX1_DR : tid_pkg::TAP_SH_DR;
            tid_pkg::TAP_SH_DR: tap_next = tms ? tid_pkg::TAP_EX1_DR : tid_pkg::TAP_SH_DR;
            tid_pkg::TAP_EX1_DR: tap_next = tms ? tid_pkg::TAP_UPD_DR : tid_pkg::TAP_PAU_DR;
            tid_pkg::TAP_PAU_DR: tap_next = tms ? tid_pkg::TAP_EX2_DR : tid_pkg::TAP_PAU_DR;
            tid_pkg::TAP_EX2_DR: tap_next = tms ? tid_pkg::TAP_UPD_DR : tid_pkg::TAP_SH_DR;
            tid_pkg::TAP_UPD_DR: tap_next = tms ? tid_pkg::TAP_SEL_DR : tid_pkg::TAP_IDLE;
            tid_pkg::TAP_SEL_IR: tap_next = tms ? tid_pkg::TAP_RESET : tid_pkg::TAP_CAP_IR;
            tid_pkg::TAP_CAP_IR: tap_next = tms ? tid_pkg::TAP_EX1_IR : tid_pkg::TAP_SH_IR;
            tid_pkg::TAP_SH_IR: tap_next = tms ? tid_pkg::TAP_EX1_IR : tid_pkg::TAP_SH_IR;
            tid_pkg::TAP_EX1_IR: tap_next = tms ? tid_pkg::TAP_UPD_IR : tid_pkg::TAP_PAU_IR;
            tid_pkg::TAP_PAU_IR: tap_next = tms ? tid_pkg::TAP_EX2_IR : tid_pkg::TAP_PAU_IR;
            tid_pkg::TAP_EX2_IR: tap_next = tms ? tid_pkg::TAP_UPD_IR : tid_pkg::TAP_SH_IR;
            tid_pkg::TAP_UPD_IR: tap_next = tms ? tid_pkg::TAP_SEL_DR : tid_pkg::TAP_IDLE;
            default: tap_next = tid_pkg::TAP_RESET;
        endcase
    end

    // Next-state logic for the whole block
    always_comb begin
        st_nxt = st_r;
        st_nxt.tck_sync = {st_r.tck_sync[tid_pkg::SYNC_W-2:0], i_tck};
        st_nxt.tms_sync = {st_r.tms_sync[0], i_tms};
        st_nxt.tdi_sync = {st_r.tdi_sync[0], i_tdi};
        // One-cycle pulses drop by default
        st_nxt.push = 1'b0;
        st_nxt.reconfig_req = 1'b0;
        st_nxt.startup_step = 1'b0;
        st_nxt.shutdown_step = 1'b0;
        st_nxt.insys_shutdown = 1'b0;
        st_nxt.insys_startup = 1'b0;
        st_nxt.readback_req = 1'b0;

        if (tck_rise) begin
            st_nxt.tap = tap_next;
            case (st_r.tap)
                tid_pkg::TAP_IDLE: begin
                    if ((st_r.ir == tid_pkg::OP_STARTUP_CLK) && i_startup_clock_source) begin
                        st_nxt.startup_step = 1'b1;
                    end
                    if (st_r.ir == tid_pkg::OP_SHUTDOWN_CLK) begin
                        st_nxt.shutdown_step = 1'b1;
                    end
                end
                tid_pkg::TAP_CAP_IR: begin
                    st_nxt.ir_shift = {tid_pkg::IR_CAP_RSVD, i_status.done,
                        i_status.init_complete, i_status.insys_config_active_flag,
                        i_status.insys_config_finished_flag, tid_pkg::IR_CAP_FIXED};
                end
                tid_pkg::TAP_SH_IR: begin
                    st_nxt.ir_shift = {tdi, st_r.ir_shift[tid_pkg::IR_W-1:1]};
                end
                tid_pkg::TAP_CAP_DR: begin
                    st_nxt.bypass_flop = 1'b0;
                    st_nxt.bit_cnt = '0;
                    if (st_r.ir == tid_pkg::OP_DEVICE_ID) begin
                        st_nxt.dr = {DEVICE_ID[31:1], 1'b1};
                    end else if (st_r.ir == tid_pkg::OP_DESIGN_ID) begin
                        st_nxt.dr = i_configured ? i_design_id
                            : tid_pkg::DESIGN_ID_BLANK;
                    end else if (cfg_read) begin
                        st_nxt.dr = i_readback_word;
                        st_nxt.readback_req = 1'b1;
                    end
                end
                tid_pkg::TAP_SH_DR: begin
                    st_nxt.bypass_flop = tdi;
                    if (cfg_path) begin
                        // Most significant bit leaves and enters first
                        st_nxt.dr = {st_r.dr[tid_pkg::DR_W-2:0], tdi};
                        st_nxt.bit_cnt = st_r.bit_cnt + 1'b1;
                        if (st_r.bit_cnt == '1) begin
                            if (cfg_load) begin
                                // A full FIFO cannot stall the host, so the word is flagged lost
                                st_nxt.push = fifo_ready;
                                st_nxt.push_word = {st_r.dr[tid_pkg::DR_W-2:0], tdi};
                                st_nxt.overrun = st_r.overrun || !fifo_ready;
                            end else begin
                                st_nxt.dr = i_readback_word;
                                st_nxt.readback_req = 1'b1;
                            end
                        end
                    end else begin
                        st_nxt.dr = {tdi, st_r.dr[tid_pkg::DR_W-1:1]};
                    end
                end
                default: begin
                end
            endcase
        end

        if (tck_fall) begin
            // Output changes on the falling edge so the host samples it stable
            st_nxt.tdo_oe = (st_r.tap == tid_pkg::TAP_SH_IR) || (st_r.tap == tid_pkg::TAP_SH_DR);
            if (st_r.tap == tid_pkg::TAP_SH_IR) begin
                st_nxt.tdo = st_r.ir_shift[0];
            end else if (st_r.tap == tid_pkg::TAP_SH_DR) begin
                st_nxt.tdo = dr_tdo;
            end
            if (st_r.tap == tid_pkg::TAP_RESET) begin
                st_nxt.ir = tid_pkg::OP_DEVICE_ID;
                st_nxt.overrun = 1'b0;
            end else if (st_r.tap == tid_pkg::TAP_UPD_IR) begin
                st_nxt.ir = st_r.ir_shift;
                case (st_r.ir_shift)
                    tid_pkg::OP_RECONFIG_REQ: st_nxt.reconfig_req = 1'b1;
                    tid_pkg::OP_INSYS_ENABLE: st_nxt.insys_shutdown = 1'b1;
                    tid_pkg::OP_SECURITY_TOGGLE: st_nxt.secure = !st_r.secure;
                    tid_pkg::OP_INSYS_DISABLE: st_nxt.insys_startup = 1'b1;
                    default: begin
                        // No-op and undefined codes take no action
                        st_nxt.secure = st_r.secure;
                    end
                endcase
            end
        end
    end

    // State register
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            st_r <= '0;
            st_r.tap <= tid_pkg::TAP_RESET;
            st_r.ir <= tid_pkg::OP_DEVICE_ID;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Loaded configuration words queue toward the engine
    tid_fifo #(
        .WIDTH(tid_pkg::DR_W),
        .DEPTH(FIFO_DEPTH)
    ) u_cfg_fifo (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_in_valid(st_r.push),
        .o_in_ready(fifo_ready),
        .i_in_data(st_r.push_word),
        .o_out_valid(o_cfg_valid),
        .i_out_ready(i_cfg_ready),
        .o_out_data(o_cfg_word)
    );
endmodule : tid_decode

//--- rtl/tid_decode_dummy_unused.sv
`timescale 1ns/1ps

//--- bench/tid_decode_monitor.sv
`timescale 1ns/1ps
// Port checks on the decoder, all in the system clock domain
module tid_decode_monitor (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_configured,
    input wire logic i_startup_clock_source,
    input wire logic i_cfg_ready,
    input wire logic o_tdo_oe,
    input wire logic o_secure,
    input wire tid_pkg::tid_user_port_s o_user,
    input wire logic o_bscan_extest,
    input wire logic o_bscan_sample,
    input wire logic o_bscan_intest,
    input wire logic o_highz,
    input wire logic o_key_read,
    input wire logic o_insys_program_en,
    input wire logic o_reconfig_req,
    input wire logic o_startup_step,
    input wire logic o_shutdown_step,
    input wire logic o_cfg_valid,
    input wire logic [31:0] o_cfg_word
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    AST_BSCAN_ONE: assert property (
        $onehot0({o_bscan_extest, o_bscan_sample, o_bscan_intest}))
        else $error("boundary modes overlap");
    AST_USER_ONE: assert property ($onehot0(o_user.sel))
        else $error("two user chains selected");
    AST_USER_GATE: assert property (!i_configured [*3] |-> o_user.sel == 4'h0)
        else $error("user chain selected while blank");
    AST_HIGHZ_ALONE: assert property (o_highz |-> !o_bscan_extest && !o_key_read)
        else $error("float mode mixed with another");
    AST_KEY_ALONE: assert property (o_key_read |-> !o_insys_program_en)
        else $error("key read during programming");
    AST_RECONF_PULSE: assert property ($rose(o_reconfig_req) |=> !o_reconfig_req)
        else $error("reconfig request too long");
    AST_START_SRC: assert property (
        o_startup_step |-> i_startup_clock_source && !o_shutdown_step)
        else $error("startup step without scan clock source");
    AST_SECURE_QUIET: assert property (!$stable(o_secure) |-> !o_tdo_oe)
        else $error("security state moved during shift");
    AST_CFG_HOLD: assert property (
        o_cfg_valid && !i_cfg_ready |=> o_cfg_valid && $stable(o_cfg_word))
        else $error("config word dropped before pop");
endmodule : tid_decode_monitor

bind tid_decode tid_decode_monitor tid_decode_monitor_i (.*);

//--- bench/tid_host.sv
`timescale 1ns/1ps
// Scan host; link clock rests low between operations
module tid_host (
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    input wire logic i_tdo
);
    initial begin
        o_tck = 1'h0;
        o_tms = 1'h1;
        o_tdi = 1'h0;
    end
    // One link clock of 160 ns; data out taken at the rising edge
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        o_tms = tms;
        o_tdi = tdi;
        #80;
        tdo = i_tdo;
        o_tck = 1'h1;
        #80;
        o_tck = 1'h0;
        o_tdi = ~tdi; // Stale data never looks valid
    endtask : tick
    // Run-Test/Idle clocks
    task automatic idle(input int n);
        logic d;
        repeat (n) tick(1'h0, 1'h0, d);
    endtask : idle
    // Five ones reach Test-Logic-Reset, then park in Run-Test/Idle
    task automatic reset_tap();
        logic d;
        repeat (5) tick(1'h1, 1'h0, d);
        tick(1'h0, 1'h0, d);
    endtask : reset_tap
    // Shift n bits, bit 0 first, from idle back to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic d;
        dout = '0;
        tick(1'h1, 1'h0, d);
        if (ir) begin
            tick(1'h1, 1'h0, d);
        end
        repeat (2) tick(1'h0, 1'h0, d);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], d);
            dout[i] = d;
        end
        tick(1'h1, 1'h0, d);
        tick(1'h0, 1'h0, d);
    endtask : scan
endmodule : tid_host

//--- bench/test_tap_instruction_decode.sv
`timescale 1ns/1ps
// Decoder under a scan host model; expectations from the opcode table
module test_tap_instruction_decode;
    logic i_ref_clk = 1'h0;
    logic i_reset = 1'h1;
    logic i_configured = 1'h0;
    logic i_cfg_ready = 1'h0;
    logic i_startup_clock_source = 1'h1;
    logic tck, tms, tdi, o_tdo, o_cfg_valid, o_secure, o_cfg_overrun;
    logic ext, smp, itst, hz, mon, key, pen, rcf, sst, sdn, isd, isu, rbq;
    logic [31:0] o_cfg_word;
    logic [31:0] w = 32'hC0DE5A17;
    logic [31:0] design_id = 32'h13579BDF;
    tid_pkg::tid_cfg_status_s st = 4'hB;
    tid_pkg::tid_user_port_s o_user;
    int bad_count = 0;
    int compares = 0;
    int cyc = 0;
    int nst = 0;
    int nsd = 0;
    int nrc = 0;
    int nie = 0;
    int niu = 0;
    int nrb = 0;
    always #5 i_ref_clk = ~i_ref_clk;
    tid_host tid_host_i (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(o_tdo));
    tid_decode #(.FIFO_DEPTH(4)) tid_decode_i (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .o_tdo(o_tdo), .o_tdo_oe(), .i_status(st),
        .i_configured(i_configured), .i_design_id(design_id),
        .i_startup_clock_source(i_startup_clock_source), .i_readback_word(w),
        .i_bscan_tdo(~tdi), .i_user_tdo(4'h0), .i_mon_tdo(tdi), .o_bscan_extest(ext),
        .o_bscan_sample(smp), .o_bscan_intest(itst), .o_highz(hz), .o_mon_sel(mon),
        .o_key_read(key), .o_insys_program_en(pen), .o_secure(o_secure), .o_user(o_user),
        .o_reconfig_req(rcf), .o_startup_step(sst), .o_shutdown_step(sdn),
        .o_insys_shutdown(isd), .o_insys_startup(isu), .o_readback_req(rbq),
        .o_cfg_overrun(o_cfg_overrun), .o_cfg_valid(o_cfg_valid), .i_cfg_ready(i_cfg_ready),
        .o_cfg_word(o_cfg_word));
    // Pulse tallies and the hang limit; the run needs about 11600 cycles
    always @(posedge i_ref_clk) begin
        nst <= nst + int'(sst);
        nsd <= nsd + int'(sdn);
        nrc <= nrc + int'(rcf);
        nie <= nie + int'(isd);
        niu <= niu + int'(isu);
        nrb <= nrb + int'(rbq);
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            bad_count++;
            results();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic ir(input logic [9:0] op);
        logic [31:0] r;
        tid_host_i.scan(1'h1, 10, 32'(op), r);
    endtask : ir
    task automatic results();
        $display("compares=%0d bad=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results
    initial begin
        logic [31:0] r;
        logic [31:0] rw;
        logic [9:0] ops [12];
        logic [9:0] byp [3];
        ops = '{tid_pkg::OP_EXTEST, tid_pkg::OP_SAMPLE, tid_pkg::OP_INTEST, tid_pkg::OP_HIGHZ,
            tid_pkg::OP_MONITOR_PORT, tid_pkg::OP_INSYS_READ, tid_pkg::OP_INSYS_PROGRAM,
            tid_pkg::OP_USER_CHAIN_D, tid_pkg::OP_USER_CHAIN_C, tid_pkg::OP_USER_CHAIN_B,
            tid_pkg::OP_USER_CHAIN_A, tid_pkg::OP_BYPASS};
        byp = '{tid_pkg::OP_BYPASS, 10'h000, tid_pkg::OP_HIGHZ};
        // Serial order of a config word: word bit 31 travels first
        for (int b = 0; b < 32; b++) begin
            rw[b] = w[31 - b];
        end
        repeat (6) @(posedge i_ref_clk);
        #1 i_reset = 1'h0;
        // Identification and capture pattern, blank and then configured
        tid_host_i.reset_tap();
        tid_host_i.scan(1'h0, 32, 32'h0, r);
        check(r, tid_pkg::DEVICE_ID_DEFAULT);
        check(32'(r[0]), 32'h1);
        tid_host_i.scan(1'h1, 10, 32'(tid_pkg::OP_DESIGN_ID), r);
        check(r, {26'h0, st, 2'h1});
        tid_host_i.scan(1'h0, 32, 32'h0, r);
        check(r, 32'hFFFFFFFF);
        ir(tid_pkg::OP_USER_CHAIN_A);
        check(32'(o_user.sel), 32'h0);
        @(posedge i_ref_clk) #1 i_configured = 1'h1;
        ir(tid_pkg::OP_DESIGN_ID);
        tid_host_i.scan(1'h0, 32, 32'h0, r);
        check(r, design_id);
        $display("test ids done");
        // Each decoded mode alone on its output
        for (int k = 0; k < 12; k++) begin
            ir(ops[k]);
            r = 32'({ext, smp, itst, hz, mon, key, pen, o_user.sel});
            check(r, 32'h400 >> k);
        end
        // Monitor return loops the scan input back, boundary return inverts it
        ir(tid_pkg::OP_MONITOR_PORT);
        tid_host_i.scan(1'h0, 8, 32'hA5, r);
        check(r, 32'hA5);
        ir(tid_pkg::OP_EXTEST);
        tid_host_i.scan(1'h0, 8, 32'hA5, r);
        check(r, 32'h5A);
        // Bypass flop: captured zero leads the shifted ones
        foreach (byp[k]) begin
            ir(byp[k]);
            tid_host_i.scan(1'h0, 2, 32'h3, r);
            check(r, 32'h2);
        end
        $display("test decode done");
        ir(tid_pkg::OP_SECURITY_TOGGLE);
        check(32'(o_secure), 32'h1);
        ir(tid_pkg::OP_RECONFIG_REQ);
        check(32'(nrc), 32'h1);
        ir(tid_pkg::OP_STARTUP_CLK);
        tid_host_i.idle(12);
        check(32'(nst), 32'hC);
        ir(tid_pkg::OP_SHUTDOWN_CLK);
        tid_host_i.idle(4);
        check(32'(nsd), 32'h4);
        // No startup steps once startup is sourced elsewhere
        @(posedge i_ref_clk) #1 i_startup_clock_source = 1'h0;
        r = 32'(nst);
        ir(tid_pkg::OP_STARTUP_CLK);
        tid_host_i.idle(4);
        check(32'(nst), r);
        ir(tid_pkg::OP_INSYS_ENABLE);
        check(32'(nie), 32'h1);
        ir(tid_pkg::OP_INSYS_DISABLE);
        check(32'(niu), 32'h1);
        $display("test actions done");
        // Config word held until popped; readback leaves word bit 31 first
        ir(tid_pkg::OP_CFG_LOAD);
        tid_host_i.scan(1'h0, 32, rw, r);
        check(32'(o_cfg_valid), 32'h1);
        check(o_cfg_word, w);
        @(posedge i_ref_clk) #1 i_cfg_ready = 1'h1;
        @(posedge i_ref_clk) #1 i_cfg_ready = 1'h0;
        check(32'({o_cfg_valid, o_cfg_overrun}), 32'h0);
        ir(tid_pkg::OP_CFG_READ);
        tid_host_i.scan(1'h0, 32, 32'h0, r);
        check(r, rw);
        check(32'(nrb), 32'h2);
        $display("test config done");
        results();
    end
endmodule : test_tap_instruction_decode
